// ==== pkg/sfpf_map.vh ====
// constants for the serial flash protection and framing front end
`ifndef SFPF_MAP_VH
`define SFPF_MAP_VH
`define SFPF_ADDR_W 20
`define SFPF_ARRAY_TOP 20'hfffff
`define SFPF_BLOCK_SHIFT 16
`define SFPF_SECTOR_SHIFT 12
`define SFPF_OP_WREN 8'h06
`define SFPF_OP_WRDI 8'h04
`define SFPF_OP_RDSR1 8'h05
`define SFPF_OP_RDSR2 8'h35
`define SFPF_OP_WRSR1 8'h01
`define SFPF_OP_WRSR2 8'h31
`define SFPF_OP_PP 8'h02
`define SFPF_OP_QPP 8'h32
`define SFPF_OP_SE 8'h20
`define SFPF_OP_BE32 8'h52
`define SFPF_OP_BE64 8'hd8
`define SFPF_OP_CE1 8'hc7
`define SFPF_OP_CE2 8'h60
`define SFPF_OP_RDID_S 8'hab
`define SFPF_OP_MDID 8'h90
`define SFPF_OP_MDID2 8'h92
`define SFPF_OP_MDID4 8'h94
`define SFPF_OP_JEDEC 8'h9f
`define SFPF_SIZE_SE 20'h00fff
`define SFPF_SIZE_BE32 20'h07fff
`define SFPF_SIZE_BE64 20'h0ffff
`define SFPF_SIZE_PAGE 20'h000ff
`define SFPF_ID_HDR_BYTES 3'd3
`define SFPF_BUSY_CYCLES 16'd2000
`endif

// ==== src/sfpf_protect_decode.v ====
// decodes the status protection bits into a protected address range
`timescale 1ns/1ps
`include "sfpf_map.vh"
module sfpf_protect_decode (
    input wire i_complement_protect,
    input wire i_sector_granularity,
    input wire i_bottom_select,
    input wire [2:0] i_protect_level,
    output reg o_any,
    output reg o_all,
    output reg [19:0] o_lo,
    output reg [19:0] o_hi
);
    reg [19:0] size;
    reg none_base;
    reg all_base;
    reg [19:0] blo;
    reg [19:0] bhi;
    // base region, then complement inverts it
    always @* begin
        size = 20'h00000;
        none_base = (i_protect_level == 3'd0);
        all_base = (i_protect_level[2:1] == 2'b11) ||
                   (i_protect_level == 3'd5 && !i_sector_granularity);
        if (i_sector_granularity) begin
            // 10x gives 32KB regardless of the low bit
            case (i_protect_level)
                3'd1: size = 20'h01000;
                3'd2: size = 20'h02000;
                3'd3: size = 20'h04000;
                default: size = 20'h08000;
            endcase
        end else begin
            // block granularity
            case (i_protect_level)
                3'd1: size = 20'h10000;
                3'd2: size = 20'h20000;
                3'd3: size = 20'h40000;
                default: size = 20'h80000;
            endcase
        end
        if (i_bottom_select) begin
            blo = 20'h00000;
            bhi = size - 20'h00001;
        end else begin
            blo = `SFPF_ARRAY_TOP - size + 20'h00001;
            bhi = `SFPF_ARRAY_TOP;
        end
        o_lo = blo;
        o_hi = bhi;
        if (!i_complement_protect) begin
            o_any = !none_base;
            o_all = all_base;
        end else begin
            // complement of the base region
            o_any = !all_base;
            o_all = none_base;
            if (i_bottom_select) begin
                o_lo = size;
                o_hi = `SFPF_ARRAY_TOP;
            end else begin
                o_lo = 20'h00000;
                o_hi = `SFPF_ARRAY_TOP - size;
            end
        end
        if (o_all) begin
            o_lo = 20'h00000;
            o_hi = `SFPF_ARRAY_TOP;
        end
    end
endmodule // sfpf_protect_decode

// ==== src/sfpf_sync.v ====
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sfpf_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire i_clk_sys,
    input wire i_arst_n,
    input wire [W-1:0] i_d,
    output reg [W-1:0] o_q
);
    reg [W-1:0] meta;
    // first stage read only by the second
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta <= INIT;
            o_q <= INIT;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule // sfpf_sync

// ==== src/sfpf_front.v ====
// serial flash front end: instruction framing, protection check, id reads
`timescale 1ns/1ps
`include "sfpf_map.vh"
module sfpf_front #(
    parameter [7:0] MAKER_CODE = 8'h5a, // arbitrary value
    parameter [7:0] NARROW_PART_CODE = 8'h3c, // arbitrary value
    parameter [15:0] WIDE_PART_CODE = 16'h6b2d, // arbitrary value
    parameter [15:0] BUSY_CYCLES = `SFPF_BUSY_CYCLES
) (
    input wire i_clk_sys,
    input wire i_arst_n,
    input wire i_cs_n,
    input wire i_sclk,
    input wire [3:0] i_dq,
    input wire i_four_line_command_mode,
    input wire i_complement_protect,
    input wire i_sector_granularity,
    input wire i_bottom_select,
    input wire i_protect_level_msb,
    input wire i_protect_level_mid,
    input wire i_protect_level_lsb,
    input wire i_op_fail,
    output reg [3:0] o_dq,
    output reg [3:0] o_dq_oe,
    output reg o_busy,
    output reg o_write_enable_latch,
    output reg o_fail_flag,
    output reg o_exec_strobe,
    output reg [7:0] o_exec_opcode,
    output reg [19:0] o_exec_addr,
    output reg o_reject_protect,
    output reg o_reject_frame
);
    wire cs_n_s;
    wire sclk_s;
    wire [3:0] dq_s;
    wire p_any;
    wire p_all;
    wire [19:0] p_lo;
    wire [19:0] p_hi;
    reg sclk_d;
    reg cs_d;
    reg [7:0] shreg;
    reg [2:0] bitcnt;
    reg [3:0] bytecnt;
    reg [7:0] opcode;
    reg [23:0] addr;
    reg [15:0] busy_cnt;
    reg [7:0] out_byte;
    reg out_go;
    reg out_active;
    reg frame_open;
    reg [7:0] next_byte;
    reg [19:0] t_lo;
    reg [19:0] t_hi;
    reg t_whole;
    reg t_is_write;
    reg t_is_array;
    reg hit;
    wire rise;
    wire fall;
    wire cs_rise;
    wire cs_fall;
    wire [7:0] shift_in;
    wire [2:0] bits_per_clk_m1;

    sfpf_sync #(.W(1), .INIT(1'b1)) u_cs (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_d(i_cs_n),
        .o_q(cs_n_s)
    );
    sfpf_sync #(.W(5), .INIT(5'h00)) u_pins (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_d({i_sclk, i_dq}),
        .o_q({sclk_s, dq_s})
    );
    sfpf_protect_decode u_dec (
        .i_complement_protect(i_complement_protect),
        .i_sector_granularity(i_sector_granularity),
        .i_bottom_select(i_bottom_select),
        .i_protect_level({i_protect_level_msb, i_protect_level_mid, i_protect_level_lsb}),
        .o_any(p_any),
        .o_all(p_all),
        .o_lo(p_lo),
        .o_hi(p_hi)
    );

    // edge detection on synchronised pins
    assign rise = sclk_s && !sclk_d;
    assign fall = !sclk_s && sclk_d;
    assign cs_rise = cs_n_s && !cs_d;
    assign cs_fall = !cs_n_s && cs_d;
    // single line takes one bit, four-line one nibble, msb first
    assign shift_in = i_four_line_command_mode ? {shreg[3:0], dq_s} : {shreg[6:0], dq_s[0]};
    assign bits_per_clk_m1 = i_four_line_command_mode ? 3'd1 : 3'd7;

    // classify the completed instruction and its target range
    always @* begin
        t_is_write = 1'b0;
        t_is_array = 1'b0;
        t_whole = 1'b0;
        t_lo = addr[19:0];
        t_hi = addr[19:0];
        case (opcode)
            `SFPF_OP_WREN, `SFPF_OP_WRDI, `SFPF_OP_WRSR1, `SFPF_OP_WRSR2: begin
                t_is_write = 1'b1;
            end
            `SFPF_OP_PP, `SFPF_OP_QPP: begin
                t_is_write = 1'b1;
                t_is_array = 1'b1;
                t_lo = {addr[19:8], 8'h00};
                t_hi = {addr[19:8], 8'h00} | `SFPF_SIZE_PAGE;
            end
            `SFPF_OP_SE: begin
                t_is_write = 1'b1;
                t_is_array = 1'b1;
                t_lo = addr[19:0] & ~`SFPF_SIZE_SE;
                t_hi = addr[19:0] | `SFPF_SIZE_SE;
            end
            `SFPF_OP_BE32: begin
                t_is_write = 1'b1;
                t_is_array = 1'b1;
                t_lo = addr[19:0] & ~`SFPF_SIZE_BE32;
                t_hi = addr[19:0] | `SFPF_SIZE_BE32;
            end
            `SFPF_OP_BE64: begin
                t_is_write = 1'b1;
                t_is_array = 1'b1;
                t_lo = addr[19:0] & ~`SFPF_SIZE_BE64;
                t_hi = addr[19:0] | `SFPF_SIZE_BE64;
            end
            `SFPF_OP_CE1, `SFPF_OP_CE2: begin
                t_is_write = 1'b1;
                t_is_array = 1'b1;
                t_whole = 1'b1;
            end
            default: begin
                t_is_write = 1'b0;
            end
        endcase
        // overlap of every touched address with the protected range
        if (!p_any) begin
            hit = 1'b0;
        end else if (t_whole) begin
            hit = 1'b1;
        end else begin
            hit = (t_lo <= p_hi) && (t_hi >= p_lo);
        end
    end

    // identification or status byte for the current output position
    always @* begin
        next_byte = 8'h00;
        case (opcode)
            `SFPF_OP_RDID_S: begin
                next_byte = NARROW_PART_CODE;
            end
            `SFPF_OP_MDID, `SFPF_OP_MDID2, `SFPF_OP_MDID4: begin
                next_byte = bytecnt[0] ? NARROW_PART_CODE : MAKER_CODE;
            end
            `SFPF_OP_JEDEC: begin
                case (bytecnt)
                    4'd1: next_byte = MAKER_CODE;
                    4'd2: next_byte = WIDE_PART_CODE[15:8];
                    default: next_byte = WIDE_PART_CODE[7:0];
                endcase
            end
            `SFPF_OP_RDSR1: begin
                next_byte = {6'h00, o_write_enable_latch, o_busy};
            end
            default: begin
                next_byte = 8'h00;
            end
        endcase
    end

    // an answer byte may begin at each byte boundary of an id or status read;
    // a busy device answers only the status read
    always @* begin
        out_go = 1'b0;
        if (bitcnt == 3'd0 && bytecnt != 4'd0) begin
            case (opcode)
                `SFPF_OP_RDSR1: begin
                    out_go = 1'b1;
                end
                `SFPF_OP_JEDEC: begin
                    out_go = !o_busy;
                end
                `SFPF_OP_RDID_S, `SFPF_OP_MDID, `SFPF_OP_MDID2, `SFPF_OP_MDID4: begin
                    out_go = !o_busy && (bytecnt >= 4'd4); // three dummy bytes first
                end
                default: begin
                    out_go = 1'b0;
                end
            endcase
        end
    end

    // framing, shifting, command completion
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
            shreg <= 8'h00;
            bitcnt <= 3'd0;
            bytecnt <= 4'd0;
            opcode <= 8'h00;
            addr <= 24'h000000;
            busy_cnt <= 16'h0000;
            out_byte <= 8'h00;
            out_active <= 1'b0;
            frame_open <= 1'b0;
            o_dq <= 4'h0;
            o_dq_oe <= 4'h0;
            o_busy <= 1'b0;
            o_write_enable_latch <= 1'b0;
            o_fail_flag <= 1'b0;
            o_exec_strobe <= 1'b0;
            o_exec_opcode <= 8'h00;
            o_exec_addr <= 20'h00000;
            o_reject_protect <= 1'b0;
            o_reject_frame <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            cs_d <= cs_n_s;
            o_exec_strobe <= 1'b0;
            o_reject_protect <= 1'b0;
            o_reject_frame <= 1'b0;
            // busy timer for program, erase and status writes
            if (o_busy) begin
                if (busy_cnt == 16'h0000) begin
                    o_busy <= 1'b0;
                    if (i_op_fail) begin
                        o_fail_flag <= 1'b1; // genuine failure only
                    end
                end else begin
                    busy_cnt <= busy_cnt - 16'h0001;
                end
            end
            if (cs_fall) begin
                // new instruction
                frame_open <= 1'b1;
                bitcnt <= 3'd0;
                bytecnt <= 4'd0;
                shreg <= 8'h00;
                out_active <= 1'b0;
            end else if (cs_rise) begin
                // instruction ends; reads just stop here
                frame_open <= 1'b0;
                out_active <= 1'b0;
                o_dq_oe <= 4'h0;
                if (t_is_write && !o_busy && bytecnt != 4'd0) begin
                    if (bitcnt != 3'd0) begin
                        o_reject_frame <= 1'b1;
                    end else if (opcode == `SFPF_OP_WREN) begin
                        o_write_enable_latch <= 1'b1;
                        o_fail_flag <= 1'b0;
                    end else if (opcode == `SFPF_OP_WRDI) begin
                        o_write_enable_latch <= 1'b0;
                    end else if (o_write_enable_latch) begin
                        o_write_enable_latch <= 1'b0;
                        if (t_is_array && hit) begin
                            o_reject_protect <= 1'b1; // array left alone
                        end else begin
                            o_exec_strobe <= 1'b1;
                            o_exec_opcode <= opcode;
                            o_exec_addr <= addr[19:0];
                            o_busy <= 1'b1;
                            busy_cnt <= BUSY_CYCLES;
                        end
                    end
                end
            end else if (frame_open && !cs_n_s) begin
                if (rise) begin
                    // sample on rising edge
                    shreg <= shift_in;
                    if (bitcnt == bits_per_clk_m1) begin
                        bitcnt <= 3'd0;
                        if (bytecnt != 4'hf) begin
                            bytecnt <= bytecnt + 4'd1;
                        end
                        if (bytecnt == 4'd0) begin
                            opcode <= shift_in; // first byte is the opcode
                        end else if (bytecnt <= 4'd3) begin
                            addr <= {addr[15:0], shift_in};
                        end
                    end else begin
                        bitcnt <= bitcnt + 3'd1;
                    end
                end
                // latch the answer byte at its boundary
                if (fall && out_go) begin
                    out_active <= 1'b1;
                    out_byte <= next_byte;
                end
                // the top bit or nibble leaves on the very fall that starts the byte,
                // so the host already finds it at its next rising edge
                if (fall && (out_active || out_go)) begin
                    // shift answer out on falling edges, msb first
                    if (i_four_line_command_mode) begin
                        o_dq <= (bitcnt == 3'd0) ? next_byte[7:4] : out_byte[3:0];
                        o_dq_oe <= 4'hf;
                    end else begin
                        o_dq <= {2'b00, ((bitcnt == 3'd0) ? next_byte[7] : out_byte[7 - bitcnt]),
                                 1'b0};
                        o_dq_oe <= 4'h2;
                    end
                end else if (fall && bitcnt == 3'd0 && bytecnt != 4'd0 && !out_active) begin
                    o_dq_oe <= 4'h0;
                end
            end
        end
    end
endmodule // sfpf_front

// ==== verif/sfpf_checker.sv ====
// port checker for the flash front end
`timescale 1ns/1ps
module sfpf_checker (
    input wire i_clk_sys,
    input wire i_arst_n,
    input wire i_cs_n,
    input wire i_four_line_command_mode,
    input wire [3:0] o_dq_oe,
    input wire o_busy,
    input wire o_fail_flag,
    input wire o_exec_strobe,
    input wire [19:0] o_exec_addr,
    input wire o_reject_protect,
    input wire o_reject_frame
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    // outcome pulses of a completed instruction, and lanes driven for answers
    chk_one_outcome: assert property (!(o_exec_strobe && o_reject_protect))
        else $error("strobe with reject");
    chk_strobe_at_rise: assert property (o_exec_strobe |-> $past(i_cs_n, 3))
        else $error("strobe not after select rise");
    chk_strobe_pulse: assert property (o_exec_strobe |=> !o_exec_strobe)
        else $error("strobe too long");
    chk_strobe_busy: assert property (o_exec_strobe |-> ##[0:1] o_busy)
        else $error("no busy after strobe");
    chk_busy_silent: assert property (o_busy && $past(o_busy) |-> !o_exec_strobe)
        else $error("strobe while busy");
    chk_frame_refused: assert property (o_reject_frame |-> !o_exec_strobe)
        else $error("partial byte accepted");
    chk_reject_no_fail: assert property (o_reject_protect |=> !$rose(o_fail_flag))
        else $error("fail set by reject");
    chk_fail_at_end: assert property ($rose(o_fail_flag) |-> $past(o_busy, 1) || $past(o_busy, 2))
        else $error("fail not at busy end");
    chk_oe_in_frame: assert property (|o_dq_oe |-> !$past(i_cs_n, 8))
        else $error("drive outside frame");
    chk_quad_lanes: assert property (o_dq_oe == 4'hf |-> i_four_line_command_mode)
        else $error("four lanes in single mode");
    chk_single_lane: assert property (o_dq_oe == 4'h2 |-> !i_four_line_command_mode)
        else $error("one lane in four-line mode");
    chk_addr_held: assert property (!o_exec_strobe |-> $stable(o_exec_addr))
        else $error("address moved");
    // main scenarios reached
    cover property (o_exec_strobe);
    cover property (o_reject_protect);
    cover property (o_reject_frame);
    cover property (o_dq_oe == 4'hf);
endmodule // sfpf_checker
bind sfpf_front sfpf_checker chk_u (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_cs_n(i_cs_n),
    .i_four_line_command_mode(i_four_line_command_mode), .o_dq_oe(o_dq_oe),
    .o_busy(o_busy), .o_fail_flag(o_fail_flag), .o_exec_strobe(o_exec_strobe),
    .o_exec_addr(o_exec_addr), .o_reject_protect(o_reject_protect),
    .o_reject_frame(o_reject_frame)
);

// ==== verif/sfpf_host.sv ====
// host controller model driving select, serial clock and data pins
`timescale 1ns/1ps
module sfpf_host (
    input wire i_clk_sys,
    input wire i_quad,
    input wire [3:0] i_pin,
    output reg o_cs_n,
    output reg o_sclk,
    output reg [3:0] o_dq
);
    // idle: deselected, clock low
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_dq = 4'h0;
    end
    task tick(input integer n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // select low opens a frame
    task open;
        tick(1);
        o_cs_n <= 1'b0;
        tick(4);
    endtask
    // select high may follow any bit; released lines then toggle
    task close;
        tick(4);
        o_cs_n <= 1'b1;
        o_dq <= ~o_dq;
        tick(12);
    endtask
    // n bit or nibble slots, msb first, data set while the clock is low
    task shift(input [7:0] b, input integer n, output [7:0] r);
        integer k;
        reg [7:0] s;
        s = b;
        r = 8'h00;
        for (k = 0; k < n; k = k + 1) begin
            if (i_quad) begin
                o_dq <= s[7:4];
                s = s << 4;
            end else begin
                o_dq <= {~s[7], ~s[7], ~s[7], s[7]};
                s = s << 1;
            end
            tick(4);
            o_sclk <= 1'b1;
            tick(1);
            r = i_quad ? {r[3:0], i_pin} : {r[6:0], i_pin[1]};
            tick(3);
            o_sclk <= 1'b0;
        end
    endtask
endmodule // sfpf_host

// ==== verif/sfpf_front_test.sv ====
// self-checking bench for the flash front end
`timescale 1ns/1ps
`include "sfpf_map.vh"
module sfpf_front_test;
    localparam [7:0] MK = 8'hc6; // arbitrary value
    localparam [7:0] NP = 8'h29; // arbitrary value
    localparam [15:0] WP = 16'h7e31; // arbitrary value
    reg i_clk_sys = 1'b0;
    reg i_arst_n = 1'b0;
    reg quad = 1'b0;
    reg [5:0] prot = 6'h00; // complement, sector, bottom, level
    reg op_fail = 1'b0;
    wire cs_n, sclk, busy, fail, stb, rjp, rjf, wel;
    wire [3:0] hdq, ddq, doe, pin;
    wire [7:0] xop;
    wire [19:0] xad;
    integer miscompares = 0;
    integer checked = 0;
    integer n_stb = 0, n_rjp = 0, n_rjf = 0, n_oe = 0, s0, p0, f0;
    reg [7:0] r;
    always #20 i_clk_sys = ~i_clk_sys;
    // driven lanes win over the host's lines
    assign pin = (doe & ddq) | (~doe & hdq);
    sfpf_host host_u (.i_clk_sys(i_clk_sys), .i_quad(quad), .i_pin(pin),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_dq(hdq));
    sfpf_front #(.MAKER_CODE(MK), .NARROW_PART_CODE(NP), .WIDE_PART_CODE(WP),
        .BUSY_CYCLES(16'd400)) dut_u (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_dq(pin), .i_four_line_command_mode(quad), .i_complement_protect(prot[5]),
        .i_sector_granularity(prot[4]), .i_bottom_select(prot[3]),
        .i_protect_level_msb(prot[2]), .i_protect_level_mid(prot[1]),
        .i_protect_level_lsb(prot[0]), .i_op_fail(op_fail), .o_dq(ddq), .o_dq_oe(doe),
        .o_busy(busy), .o_write_enable_latch(wel), .o_fail_flag(fail), .o_exec_strobe(stb),
        .o_exec_opcode(xop), .o_exec_addr(xad), .o_reject_protect(rjp),
        .o_reject_frame(rjf));
    // pulse and drive counters
    always @(posedge i_clk_sys) begin
        n_stb <= n_stb + stb;
        n_rjp <= n_rjp + rjp;
        n_rjf <= n_rjf + rjf;
        n_oe <= n_oe + (|doe);
    end
    task check(input [31:0] got, input [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task bx(input [7:0] b);
        host_u.shift(b, quad ? 2 : 8, r);
    endtask
    task cmd(input [7:0] op);
        host_u.open;
        bx(op);
        host_u.close;
    endtask
    task mark;
        s0 = n_stb;
        p0 = n_rjp;
        f0 = n_rjf;
    endtask
    // write enable, then opcode, address and stray bits
    task array_op(input [7:0] op, input [19:0] a, input integer extra);
        cmd(`SFPF_OP_WREN);
        host_u.open;
        bx(op);
        bx({4'h0, a[19:16]});
        bx(a[15:8]);
        bx(a[7:0]);
        if (extra > 0) host_u.shift(8'ha5, extra, r);
        host_u.close;
    endtask
    // pulse counts since the mark, then a bounded wait for idle
    task outcome(input integer s, input integer p, input integer f);
        integer k;
        check(n_stb - s0, s);
        check(n_rjp - p0, p);
        check(n_rjf - f0, f);
        for (k = 0; k < 2000 && busy !== 1'b0; k = k + 1) @(posedge i_clk_sys);
        check(busy, 1'b0);
    endtask
    function [20:0] size_of(input [5:0] p);
        if (p[4]) size_of = 21'h1000 << (p[2] ? 3'd3 : p[2:0] - 3'd1);
        else size_of = 21'h10000 << (p[2:0] - 3'd1);
    endfunction
    // expected protection of one 4KB sector
    function prot_hit(input [5:0] p, input [19:0] a);
        reg all, inr;
        all = (p[2:1] == 2'b11) || (p[2:0] == 3'b101 && !p[4]);
        inr = all || (p[3] ? a < size_of(p) : a >= 21'h100000 - size_of(p));
        if (p[2:0] == 3'b000) prot_hit = p[5];
        else if (p[5]) prot_hit = !all && !inr;
        else prot_hit = inr;
    endfunction
    task rd_jedec;
        host_u.open;
        bx(`SFPF_OP_JEDEC);
        bx(8'h00); check(r, MK);
        bx(8'h00); check(r, WP[15:8]);
        bx(8'h00); check(r, WP[7:0]);
        host_u.close;
    endtask
    task t_id;
        integer k;
        rd_jedec;
        for (k = 0; k < 4; k = k + 1) begin
            host_u.open;
            bx(k == 0 ? `SFPF_OP_RDID_S : 8'h8e + 8'd2 * k[7:0]);
            repeat (3) bx(8'h00);
            if (k > 0) begin bx(8'h00); check(r, MK); end
            bx(8'h00); check(r, NP);
            host_u.close;
        end
        host_u.open;
        bx(`SFPF_OP_RDID_S);
        host_u.shift(8'h00, 3, r);
        host_u.close;
        @(posedge i_clk_sys) quad <= 1'b1;
        rd_jedec;
        @(posedge i_clk_sys) quad <= 1'b0;
        $display("id test done");
    endtask
    task t_frame;
        mark;
        array_op(`SFPF_OP_SE, 20'h12000, 4);
        outcome(0, 0, 1);
        mark;
        array_op(`SFPF_OP_SE, 20'h12000, 0);
        outcome(1, 0, 0);
        check(xop, `SFPF_OP_SE);
        check(xad, 20'h12000);
        check(wel, 1'b0);
        $display("frame test done");
    endtask
    task t_chip;
        mark;
        @(posedge i_clk_sys) prot <= 6'h07;
        cmd(`SFPF_OP_WREN);
        host_u.open;
        bx(`SFPF_OP_CE1);
        @(posedge i_clk_sys) prot <= 6'h00;
        host_u.close;
        outcome(1, 0, 0);
        @(posedge i_clk_sys) prot <= 6'h01;
        mark;
        cmd(`SFPF_OP_WREN);
        check(wel, 1'b1);
        cmd(`SFPF_OP_CE2);
        outcome(0, 1, 0);
        $display("chip erase test done");
    endtask
    task t_protect;
        integer c, j;
        reg [20:0] sz;
        reg [19:0] a, aj;
        reg [19:0] xlast;
        reg hit;
        xlast = xad;
        for (c = 0; c < 64; c = c + 1) begin
            @(posedge i_clk_sys) prot <= c[5:0];
            sz = size_of(c[5:0]);
            a = c[3] ? sz[19:0] : 20'h00000 - sz[19:0];
            for (j = 0; j < 2; j = j + 1) begin
                aj = a - 20'h01000 * j[19:0];
                hit = prot_hit(c[5:0], aj);
                mark;
                array_op(`SFPF_OP_SE, aj, 0);
                outcome(!hit, hit, 0);
                if (!hit) xlast = aj;
                check(xad, xlast);
            end
        end
        check(fail, 1'b0);
        $display("protect test done");
    endtask
    task t_busy;
        integer e;
        @(posedge i_clk_sys) prot <= 6'h00;
        op_fail <= 1'b1;
        mark;
        array_op(`SFPF_OP_SE, 20'h00000, 0);
        cmd(`SFPF_OP_WREN);
        host_u.open;
        bx(`SFPF_OP_RDSR1);
        bx(8'h00); check(r, 8'h01);
        host_u.close;
        e = n_oe;
        host_u.open;
        bx(`SFPF_OP_JEDEC);
        bx(8'h00);
        host_u.close;
        check(n_oe - e, 0);
        outcome(1, 0, 0);
        host_u.open;
        bx(`SFPF_OP_RDSR1);
        bx(8'h00); check(r, 8'h00);
        host_u.close;
        check(fail, 1'b1);
        $display("busy test done");
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        t_id;
        t_frame;
        t_chip;
        t_protect;
        t_busy;
        conclude;
    end
    // watchdog
    initial begin
        #4_000_000;
        miscompares = miscompares + 1;
        conclude;
    end
endmodule // sfpf_front_test
